// [src/pwdu_pkg.sv]
// Purpose: Constants and types for the password watchdog unit with prewarning.
// Assumes: One clock, sys_clk at 125 MHz; synchronous active-low reset.
// Notes: Control bits are plain ports; no register bus.
package pwdu_pkg;

  // ***************************************************************
  // Widths and fixed values
  // ***************************************************************
  localparam int CNT_W = 16;
  localparam logic [15:0] FIXED_RELOAD = 16'hFFFC;
  localparam logic [15:0] RESET_RELOAD = 16'h0000;
  localparam logic [7:0] FIXED_PW = 8'hA5;
  localparam logic [7:0] GUARD_PW = 8'h5A;
  localparam int DIV_LO_LOG2 = 8;
  localparam int DIV_HI_LOG2 = 14;
  localparam int PRESC_W = 14;
  localparam int SEQ_LIMIT_NS = 2048;
  localparam int CLK_NS = 8;
  localparam int SEQ_LIMIT_CYC = SEQ_LIMIT_NS / CLK_NS;
  localparam int SEQ_W = 9;

  // ***************************************************************
  // Types
  // ***************************************************************
  typedef enum logic [1:0] {
    PWDU_NORMAL = 2'b00,
    PWDU_TIMEOUT = 2'b01,
    PWDU_PREWARN = 2'b10,
    PWDU_HELD = 2'b11
  } pwdu_mode_t;

  // One software write to the control word
  typedef struct packed {
    logic [7:0] password;
    logic [7:0] guard;
    logic [15:0] reload;
    logic lock;
    logic disable_timeout;
    logic slow_clock;
  } pwdu_wr_t;

endpackage

// [src/pwdu_presc.sv]
// Purpose: Free-running prescaler giving one-cycle ticks at sys_clk/256 or /16384.
// Assumes: Synchronous active-low reset.
// Notes: The select is taken as is; a change may shorten one tick period.
module pwdu_presc #(
  parameter int PRESC_W = pwdu_pkg::PRESC_W
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Control
  input wire logic slow_clock,
  // Tick out
  output logic tick
);

  logic [PRESC_W-1:0] count;
  logic [PRESC_W-1:0] next_count;
  wire lo_hit = &count[pwdu_pkg::DIV_LO_LOG2-1:0];
  wire hi_hit = &count[pwdu_pkg::DIV_HI_LOG2-1:0];
  wire next_tick = slow_clock ? hi_hit : lo_hit;

  // Count up, wrap at full width
  assign next_count = count + {{(PRESC_W-1){1'b0}}, 1'b1};

  // Prescaler state
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      count <= '0;
      tick <= 1'b0;
    end else begin
      count <= next_count;
      tick <= next_tick;
    end
  end

endmodule

// [src/pwdu_top.sv]
// Purpose: Watchdog unit with password access, init-done lock and NMI prewarning.
// Assumes: Writes arrive as single-cycle strobes with a packed write word.
// Notes: A power-on reset input is the only way out of the held state.
module pwdu_top (
  // Clock and resets
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic poweron_resetn,
  // Software access
  input wire logic wr_strobe,
  input wire pwdu_pkg::pwdu_wr_t wr_data,
  input wire logic [7:0] user_pw,
  // Service request without control change
  input wire logic service,
  // System outputs
  output logic init_done_lock,
  output logic nmi_req,
  output logic sys_reset_req,
  output logic held_in_reset,
  output logic [15:0] count_value,
  output pwdu_pkg::pwdu_mode_t mode,
  output logic access_error,
  output logic overflow_error,
  output logic seq_open
);

  // ***************************************************************
  // Control state
  // ***************************************************************
  logic [15:0] reload;
  logic disable_timeout;
  logic slow_clock;
  logic [pwdu_pkg::SEQ_W-1:0] seq_count;
  logic wd_reset_seen;
  logic tick;

  // ***************************************************************
  // Prescaler
  // ***************************************************************
  pwdu_presc #(
    .PRESC_W(pwdu_pkg::PRESC_W)
  ) u_presc (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .slow_clock(slow_clock),
    .tick(tick)
  );

  // ***************************************************************
  // Access decode
  // ***************************************************************
  wire pw_ok = wr_data.password == (pwdu_pkg::FIXED_PW ^ user_pw);
  wire guard_ok = wr_data.guard == pwdu_pkg::GUARD_PW;
  wire seq_expired = seq_count == '0;
  wire first_wr = wr_strobe && !seq_open;
  wire second_wr = wr_strobe && seq_open;
  wire first_bad = first_wr && !pw_ok;
  wire second_bad = second_wr && !guard_ok;
  wire proper_access = second_wr && guard_ok;
  wire timeout_abort = seq_open && seq_expired && !wr_strobe;
  wire acc_err = first_bad || second_bad;
  // Held for power-on: nothing is taken during the short gaps between stretched resets
  wire active = mode != pwdu_pkg::PWDU_HELD && !held_in_reset;

  // ***************************************************************
  // Counter decode
  // ***************************************************************
  wire counting = active && tick &&
    (!disable_timeout || mode != pwdu_pkg::PWDU_NORMAL);
  wire ovf = counting && (&count_value);
  // Time-out mode services like normal mode, but a plain service reloads the fixed value
  wire svc = (service || proper_access) &&
    (mode == pwdu_pkg::PWDU_NORMAL || mode == pwdu_pkg::PWDU_TIMEOUT);
  wire err = active && (acc_err || ovf || timeout_abort);
  wire [15:0] reload_now = (mode == pwdu_pkg::PWDU_NORMAL) ? reload :
    pwdu_pkg::FIXED_RELOAD;
  wire [15:0] new_reload = proper_access ? wr_data.reload : reload;
  wire [15:0] count_inc = count_value + 16'h0001;

  // Next mode: normal -> prewarn on error, prewarn -> reset on overflow
  pwdu_pkg::pwdu_mode_t next_mode;
  always_comb begin
    next_mode = mode;
    case (mode)
      pwdu_pkg::PWDU_NORMAL: begin
        if (err) begin
          next_mode = pwdu_pkg::PWDU_PREWARN;
        end else if (proper_access && wr_data.disable_timeout) begin
          next_mode = pwdu_pkg::PWDU_NORMAL;
        end
      end
      pwdu_pkg::PWDU_TIMEOUT: begin
        if (err) begin
          next_mode = pwdu_pkg::PWDU_PREWARN;
        end else if (proper_access) begin
          next_mode = pwdu_pkg::PWDU_NORMAL;
        end
      end
      pwdu_pkg::PWDU_PREWARN: begin
        next_mode = pwdu_pkg::PWDU_PREWARN;
      end
      pwdu_pkg::PWDU_HELD: begin
        next_mode = pwdu_pkg::PWDU_HELD;
      end
      default: begin
        next_mode = pwdu_pkg::PWDU_HELD;
      end
    endcase
  end

  // Next counter value
  logic [15:0] next_count;
  always_comb begin
    next_count = count_value;
    if (!active) begin
      next_count = count_value;
    end else if (mode != pwdu_pkg::PWDU_PREWARN && err) begin
      next_count = pwdu_pkg::FIXED_RELOAD;
    end else if (svc) begin
      next_count = proper_access ? wr_data.reload : reload_now;
    end else if (counting) begin
      next_count = count_inc;
    end
  end

  // Final reset fires when the prewarning run overflows
  wire final_reset = mode == pwdu_pkg::PWDU_PREWARN && ovf;
  wire next_held = final_reset && wd_reset_seen;

  // ***************************************************************
  // Sequence window timer
  // ***************************************************************
  logic [pwdu_pkg::SEQ_W-1:0] next_seq;
  assign next_seq = (first_wr && pw_ok) ?
    pwdu_pkg::SEQ_W'(pwdu_pkg::SEQ_LIMIT_CYC) :
    (seq_open ? seq_count - {{(pwdu_pkg::SEQ_W-1){1'b0}}, 1'b1} : seq_count);
  wire next_seq_open = (first_wr && pw_ok && active) ||
    (seq_open && !wr_strobe && !seq_expired);

  // Sequence state
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      seq_open <= 1'b0;
      seq_count <= '0;
    end else begin
      seq_open <= next_seq_open;
      seq_count <= next_seq;
    end
  end

  // Control fields, updated only by a proper two-write access
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      reload <= pwdu_pkg::RESET_RELOAD;
      disable_timeout <= 1'b0;
      slow_clock <= 1'b0;
      init_done_lock <= 1'b1;
    end else if (proper_access && active) begin
      reload <= new_reload;
      disable_timeout <= wr_data.disable_timeout;
      slow_clock <= wr_data.slow_clock;
      init_done_lock <= wr_data.lock;
    end
  end

  // Counter and mode; reset enters time-out mode
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      count_value <= pwdu_pkg::FIXED_RELOAD;
      mode <= pwdu_pkg::PWDU_TIMEOUT;
    end else begin
      count_value <= next_count;
      mode <= next_held ? pwdu_pkg::PWDU_HELD : next_mode;
    end
  end

  // Held state survives system reset; only power-on reset clears it
  always_ff @(posedge sys_clk) begin
    if (!poweron_resetn) begin
      wd_reset_seen <= 1'b0;
      held_in_reset <= 1'b0;
    end else begin
      if (final_reset) begin
        wd_reset_seen <= 1'b1;
      end else if (proper_access) begin
        wd_reset_seen <= 1'b0;
      end
      if (next_held) begin
        held_in_reset <= 1'b1;
      end
    end
  end

  // Fault outputs
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      nmi_req <= 1'b0;
      sys_reset_req <= held_in_reset;
      access_error <= 1'b0;
      overflow_error <= 1'b0;
    end else begin
      nmi_req <= next_mode == pwdu_pkg::PWDU_PREWARN;
      sys_reset_req <= sys_reset_req || final_reset || held_in_reset;
      access_error <= access_error || (active && (acc_err || timeout_abort));
      overflow_error <= overflow_error || ovf;
    end
  end

  // ***************************************************************
  // Checks
  // ***************************************************************
  a_nmi_before_reset: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(sys_reset_req) && !held_in_reset |-> $past(nmi_req))
    else $error("reset without prior nmi");
  a_bad_pw_nmi: assert property (@(posedge sys_clk) disable iff (!resetn)
    first_bad && mode == pwdu_pkg::PWDU_NORMAL |=> nmi_req)
    else $error("bad password gave no nmi");
  a_ovf_nmi: assert property (@(posedge sys_clk) disable iff (!resetn)
    ovf && mode == pwdu_pkg::PWDU_NORMAL |=> nmi_req && overflow_error)
    else $error("overflow gave no nmi");
  a_prewarn_load: assert property (@(posedge sys_clk) disable iff (!resetn)
    err && mode == pwdu_pkg::PWDU_NORMAL |=> count_value == pwdu_pkg::FIXED_RELOAD)
    else $error("prewarn not loaded with fixed value");
  a_lock_stable: assert property (@(posedge sys_clk) disable iff (!resetn)
    !proper_access |=> $stable(init_done_lock))
    else $error("lock changed without proper access");
  a_seq_limit: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(seq_open) |-> ##[1:300] !seq_open)
    else $error("sequence window not limited");
  a_disabled_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
    disable_timeout && mode == pwdu_pkg::PWDU_NORMAL && !err && !svc
    |=> $stable(count_value))
    else $error("counter moved while disabled");
  a_held_sticky: assert property (@(posedge sys_clk) disable iff (!poweron_resetn)
    held_in_reset |=> held_in_reset && sys_reset_req)
    else $error("held reset released");
  a_reload_svc: assert property (@(posedge sys_clk) disable iff (!resetn)
    service && !proper_access && mode == pwdu_pkg::PWDU_NORMAL && !err
    |=> count_value == reload)
    else $error("service did not reload");
  c_proper: cover property (@(posedge sys_clk) proper_access);
  c_prewarn: cover property (@(posedge sys_clk) $rose(nmi_req));
  c_final: cover property (@(posedge sys_clk) $rose(sys_reset_req));
  c_held: cover property (@(posedge sys_clk) $rose(held_in_reset));

endmodule

// [dv/pwdu_sysmodel.sv]
// Purpose: Reset generator and NMI input that sit beyond the watchdog outputs.
// Assumes: One clock; the bench reset is synchronous and active low.
// Notes: A reset request holds the system reset low for RST_LEN cycles.
module pwdu_sysmodel #(
  parameter int RST_LEN = 12
) (
  // Clock and bench reset
  input wire logic sys_clk,
  input wire logic tb_resetn,
  // Requests from the watchdog
  input wire logic sys_reset_req,
  input wire logic nmi_req,
  // System reset and event counts
  output logic resetn,
  output int nmi_seen,
  output int resets_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  int hold_cnt;
  logic nmi_q;

  // Stretch each reset request and count NMI edges
  always_ff @(posedge sys_clk) begin
    nmi_q <= nmi_req;
    if (!tb_resetn) begin
      hold_cnt <= 0;
      resets_seen <= 0;
      nmi_seen <= 0;
    end else begin
      if (hold_cnt != 0) begin
        hold_cnt <= hold_cnt - 1;
      end else if (sys_reset_req) begin
        hold_cnt <= RST_LEN;
        resets_seen <= resets_seen + 1;
      end
      if (nmi_req && !nmi_q) begin
        nmi_seen <= nmi_seen + 1;
      end
    end
  end

  // System reset is low while the bench or a stretch holds it
  assign resetn = tb_resetn && (hold_cnt == 0);
endmodule

// [dv/pwdu_top_tb.sv]
// Purpose: Self-checking bench for the password watchdog unit.
// Assumes: Fast divider for most runs; software side is driven here.
// Notes: Seed 16; every wait is bounded and ends the run when exhausted.
module pwdu_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic tb_resetn = 1'b0;
  logic poweron_resetn = 1'b0;
  logic wr_strobe = 1'b0;
  logic service = 1'b0;
  pwdu_pkg::pwdu_wr_t wr_data = '0;
  logic [7:0] user_pw = 8'h00;
  logic resetn, init_done_lock, nmi_req, sys_reset_req, held_in_reset;
  logic access_error, overflow_error, seq_open;
  logic [15:0] count_value, r, rl;
  pwdu_pkg::pwdu_mode_t mode;
  int error_cnt = 0, check_count = 0, seed = 16, n, nmi_seen, resets_seen;

  always #4 sys_clk = ~sys_clk;

  pwdu_top dut_u (.sys_clk(sys_clk), .resetn(resetn), .poweron_resetn(poweron_resetn),
    .wr_strobe(wr_strobe), .wr_data(wr_data), .user_pw(user_pw), .service(service),
    .init_done_lock(init_done_lock), .nmi_req(nmi_req), .sys_reset_req(sys_reset_req),
    .held_in_reset(held_in_reset), .count_value(count_value), .mode(mode),
    .access_error(access_error), .overflow_error(overflow_error), .seq_open(seq_open));
  pwdu_sysmodel sysm_u (.sys_clk(sys_clk), .tb_resetn(tb_resetn),
    .sys_reset_req(sys_reset_req), .nmi_req(nmi_req), .resetn(resetn),
    .nmi_seen(nmi_seen), .resets_seen(resets_seen));

  // Checking, waiting and driving helpers
  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d, errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  function automatic logic cond(input int sel);
    case (sel)
      0: cond = (access_error === 1'b1);
      1: cond = (overflow_error === 1'b1);
      2: cond = (sys_reset_req === 1'b1);
      3: cond = (held_in_reset === 1'b1);
      4: cond = (resetn === 1'b1);
      default: cond = (count_value !== r);
    endcase
  endfunction
  task automatic wait_for(input int sel, input int lim);
    n = 0;
    while (!cond(sel)) begin
      if (n >= lim) begin
        chk(1'b0, "wait ran out");
        stop_test();
      end
      step(1);
      n++;
    end
  endtask
  function automatic logic [7:0] good_pw();
    good_pw = pwdu_pkg::FIXED_PW ^ user_pw;
  endfunction
  task automatic wr(input logic [7:0] pw, input logic [7:0] g, input logic [15:0] v,
                    input logic lk, input logic dis, input logic slow);
    @(posedge sys_clk);
    wr_strobe <= 1'b1;
    wr_data <= {pw, g, v, lk, dis, slow};
    @(posedge sys_clk);
    wr_strobe <= 1'b0;
    #1;
  endtask
  task automatic pair(input logic [15:0] v, input logic lk, input logic dis, input logic slow);
    @(posedge sys_clk);
    user_pw <= $random(seed);
    #1;
    wr(good_pw(), 8'h00, v, lk, dis, slow);
    chk(seq_open === 1'b1, "first write refused");
    wr(good_pw(), pwdu_pkg::GUARD_PW, v, lk, dis, slow);
    chk(seq_open === 1'b0 && mode === pwdu_pkg::PWDU_NORMAL, "pair not taken");
    chk(count_value === v && init_done_lock === lk, "reload or lock");
  endtask
  task automatic tick_gap(input int cyc);
    r = count_value;
    wait_for(5, cyc + 4);
    r = count_value;
    wait_for(5, cyc + 4);
    chk(n == cyc, "tick spacing");
  endtask
  task automatic reset_all();
    @(posedge sys_clk);
    tb_resetn <= 1'b0;
    poweron_resetn <= 1'b0;
    step(10);
    tb_resetn <= 1'b1;
    poweron_resetn <= 1'b1;
    step(1);
  endtask

  // Main sequence
  initial begin
    reset_all();
    chk(mode === pwdu_pkg::PWDU_TIMEOUT && count_value === pwdu_pkg::FIXED_RELOAD, "rst");
    chk(init_done_lock === 1'b1 && nmi_req === 1'b0 && seq_open === 1'b0, "rst outs");
    pair(16'h0000, 1'b0, 1'b0, 1'b0);
    tick_gap(256);
    rl = 16'hFFF0 | 16'($random(seed) & 7);
    pair(rl, 1'b0, 1'b0, 1'b0);
    step(600);
    chk(count_value !== rl, "counter idle");
    @(posedge sys_clk);
    service <= 1'b1;
    @(posedge sys_clk);
    service <= 1'b0;
    #1;
    chk(count_value === rl, "service reload");
    wait_for(1, 17 * 256 + 10);
    step(1);
    chk(nmi_req === 1'b1 && mode === pwdu_pkg::PWDU_PREWARN, "overflow nmi");
    chk(count_value === pwdu_pkg::FIXED_RELOAD, "fixed reload");
    wait_for(2, 4 * 256 + 4);
    chk(n >= 3 * 256 - 2, "prewarn delay");
    step(2);
    wait_for(4, 100);
    chk(resets_seen == 1 && nmi_seen == 1 && overflow_error === 1'b0, "reset taken");
    pair(16'h0000, 1'b0, 1'b0, 1'b0);
    wr(~good_pw(), 8'h00, 16'h0000, 1'b0, 1'b0, 1'b0);
    step(1);
    chk(access_error === 1'b1 && nmi_req === 1'b1, "bad password");
    wait_for(2, 2100);
    step(2);
    wait_for(4, 100);
    wr(good_pw(), 8'h00, 16'h0000, 1'b0, 1'b0, 1'b0);
    wait_for(0, 300);
    chk(n >= 250, "window too short");
    wait_for(2, 2100);
    step(2);
    wait_for(3, 100);
    chk(held_in_reset === 1'b1, "double reset");
    wr(good_pw(), 8'h00, 16'h0000, 1'b0, 1'b0, 1'b0);
    chk(seq_open === 1'b0, "held took write");
    reset_all();
    chk(held_in_reset === 1'b0, "power-on clears");
    pair(16'h0000, 1'b0, 1'b1, 1'b0);
    step(600);
    chk(count_value === 16'h0000 && nmi_req === 1'b0, "disabled counts");
    wr(good_pw(), 8'h00, 16'h0000, 1'b1, 1'b1, 1'b0);
    wr(good_pw(), pwdu_pkg::GUARD_PW ^ 8'h01 << ($random(seed) & 7), 16'h0, 1'b1, 1'b1, 1'b0);
    step(1);
    chk(access_error === 1'b1 && nmi_req === 1'b1 && init_done_lock === 1'b0, "guard");
    reset_all();
    pair(16'h0000, 1'b1, 1'b0, 1'b1);
    tick_gap(16384);
    stop_test();
  end
endmodule
